// file: rtl/fsc_top.sv
// fan speed control: registers and three automatic drive loops
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps
module fsc_top
  import fsc_pkg::*;
#(
  parameter int TENTH_CYC = FSC_TENTH_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] system_temp_sense,
  input  wire logic [7:0] processor_temp_sense,
  input  wire logic [7:0] auxiliary_temp_sense,
  input  wire logic [7:0] system_fan_tach,
  input  wire logic [7:0] processor_fan_tach,
  input  wire logic [7:0] auxiliary_fan_tach,
  input  wire logic       system_overtemp_raw,
  output logic      [3:0] system_fan_drive,
  output logic      [3:0] processor_fan_drive,
  output logic      [3:0] auxiliary_fan_drive,
  output logic            overtemp_alert_n,
  output logic            regulator_formula_v9,
  output logic            regulator_formula_v8
);

  // ==========================================================================
  // input synchronisers, pin inputs from outside the clock domain
  logic [7:0] temp_s1_r [3];
  logic [7:0] temp_s2_r [3];
  logic [7:0] tach_s1_r [3];
  logic [7:0] tach_s2_r [3];
  logic [1:0] ovt_sync_r;

  always_ff @(posedge clk) begin
    temp_s1_r[0] <= system_temp_sense;
    temp_s1_r[1] <= processor_temp_sense;
    temp_s1_r[2] <= auxiliary_temp_sense;
    tach_s1_r[0] <= system_fan_tach;
    tach_s1_r[1] <= processor_fan_tach;
    tach_s1_r[2] <= auxiliary_fan_tach;
    temp_s2_r    <= temp_s1_r;
    tach_s2_r    <= tach_s1_r;
    ovt_sync_r   <= {ovt_sync_r[0], system_overtemp_raw};
  end

  // ==========================================================================
  // register file
  logic [7:0] sys_out_r, cpu_out_r, aux_out_r, cfg_a_r, cfg_b_r, cs_tol_r, aux_tol_r;
  logic [7:0] step_dn_r, step_up_r, alert_cfg_r;
  logic [7:0] tgt_r [3];
  logic [7:0] stop_r [3];
  logic [7:0] start_r [3];
  logic [7:0] stime_r [3];
  logic [2:0] warn;

  wire w_sys_out   = reg_wr && reg_addr == FSC_SYS_OUT_OFS;
  wire w_cpu_out   = reg_wr && reg_addr == FSC_CPU_OUT_OFS;
  wire w_aux_out   = reg_wr && reg_addr == FSC_AUX_OUT_OFS;
  wire w_cfg_a     = reg_wr && reg_addr == FSC_CFG_A_OFS;
  wire w_cfg_b     = reg_wr && reg_addr == FSC_CFG_B_OFS;
  wire w_cs_tol    = reg_wr && reg_addr == FSC_CS_TOL_OFS;
  wire w_aux_tol   = reg_wr && reg_addr == FSC_AUX_TOL_OFS;
  wire w_step_dn   = reg_wr && reg_addr == FSC_STEP_DN_OFS;
  wire w_step_up   = reg_wr && reg_addr == FSC_STEP_UP_OFS;
  wire w_alert_cfg = reg_wr && reg_addr == FSC_ALERT_CFG_OFS;
  wire [7:0] ofs_tgt   [3] = '{FSC_SYS_TGT_OFS, FSC_CPU_TGT_OFS, FSC_AUX_TGT_OFS};
  wire [7:0] ofs_stop  [3] = '{FSC_SYS_STOP_OFS, FSC_CPU_STOP_OFS, FSC_AUX_STOP_OFS};
  wire [7:0] ofs_start [3] = '{FSC_SYS_START_OFS, FSC_CPU_START_OFS, FSC_AUX_START_OFS};
  wire [7:0] ofs_stime [3] = '{FSC_SYS_STIME_OFS, FSC_CPU_STIME_OFS, FSC_AUX_STIME_OFS};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sys_out_r   <= FSC_OUT_RST;
      cpu_out_r   <= FSC_OUT_RST;
      aux_out_r   <= FSC_OUT_RST; // RQ13
      cfg_a_r     <= FSC_CFG_A_RST;
      cfg_b_r     <= FSC_CFG_B_RST;
      cs_tol_r    <= FSC_ZERO_RST;
      aux_tol_r   <= FSC_ZERO_RST;
      step_dn_r   <= FSC_STEP_RST;
      step_up_r   <= FSC_STEP_RST;
      alert_cfg_r <= FSC_ALERT_RST; // RQ19
    end else begin
      if (w_sys_out) sys_out_r <= reg_wdata;
      if (w_cpu_out) cpu_out_r <= reg_wdata;
      if (w_aux_out) aux_out_r <= reg_wdata;
      if (w_cfg_a) cfg_a_r <= reg_wdata;
      if (w_cfg_b) cfg_b_r <= reg_wdata;
      if (w_cs_tol) cs_tol_r <= reg_wdata;
      if (w_aux_tol) aux_tol_r <= reg_wdata;
      if (w_step_dn) step_dn_r <= reg_wdata;
      if (w_step_up) step_up_r <= reg_wdata;
      if (w_alert_cfg) alert_cfg_r <= reg_wdata;
    end
  end

  for (genvar c = 0; c < 3; c++) begin : g_creg
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        tgt_r[c]   <= FSC_ZERO_RST;
        stop_r[c]  <= FSC_STOP_RST;
        start_r[c] <= FSC_START_RST;
        stime_r[c] <= FSC_STIME_RST;
      end else begin
        if (reg_wr && reg_addr == ofs_tgt[c]) tgt_r[c] <= reg_wdata;
        if (reg_wr && reg_addr == ofs_stop[c]) stop_r[c] <= reg_wdata;
        if (reg_wr && reg_addr == ofs_start[c]) start_r[c] <= reg_wdata;
        if (reg_wr && reg_addr == ofs_stime[c]) stime_r[c] <= reg_wdata;
      end
    end
  end

  // ==========================================================================
  // read mux, data one cycle after the strobe
  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      FSC_SYS_OUT_OFS:   rd_mux = sys_out_r;
      FSC_CPU_OUT_OFS:   rd_mux = cpu_out_r;
      FSC_CFG_A_OFS:     rd_mux = cfg_a_r;
      FSC_SYS_TGT_OFS:   rd_mux = tgt_r[0];
      FSC_CPU_TGT_OFS:   rd_mux = tgt_r[1];
      FSC_CS_TOL_OFS:    rd_mux = cs_tol_r;
      FSC_SYS_STOP_OFS:  rd_mux = stop_r[0];
      FSC_CPU_STOP_OFS:  rd_mux = stop_r[1];
      FSC_SYS_START_OFS: rd_mux = start_r[0];
      FSC_CPU_START_OFS: rd_mux = start_r[1];
      FSC_SYS_STIME_OFS: rd_mux = stime_r[0];
      FSC_CPU_STIME_OFS: rd_mux = stime_r[1];
      FSC_STEP_DN_OFS:   rd_mux = step_dn_r;
      FSC_STEP_UP_OFS:   rd_mux = step_up_r;
      FSC_AUX_OUT_OFS:   rd_mux = aux_out_r;
      FSC_CFG_B_OFS:     rd_mux = cfg_b_r;
      FSC_AUX_TGT_OFS:   rd_mux = tgt_r[2];
      FSC_AUX_TOL_OFS:   rd_mux = aux_tol_r;
      FSC_AUX_STOP_OFS:  rd_mux = stop_r[2];
      FSC_AUX_START_OFS: rd_mux = start_r[2];
      FSC_AUX_STIME_OFS: rd_mux = stime_r[2];
      FSC_ALERT_CFG_OFS: rd_mux = alert_cfg_r;
      FSC_WARN_OFS:      rd_mux = {5'h00, warn};
      default:           rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) reg_rdata <= 8'h00;
    else if (reg_rd) reg_rdata <= rd_mux;
    else reg_rdata <= 8'h00;
  end

  // ==========================================================================
  // shared 0.1 s tick
  logic [31:0] tick_cnt_r;
  wire         tick = tick_cnt_r == 32'(TENTH_CYC - 1);
  always_ff @(posedge clk) begin
    if (!rst_n || tick) tick_cnt_r <= 32'h0000_0000;
    else tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
  end

  // ==========================================================================
  // channel settings
  fsc_chan_cfg_t cfg [3];
  assign cfg[0] = '{fsc_mode_t'(cfg_a_r[FSC_SYS_MODE_LSB +: 2]), tgt_r[0], cs_tol_r[3:0],
                    stop_r[0][7:4], start_r[0][7:4], stime_r[0],
                    cfg_b_r[FSC_SYS_HOLD_BIT], sys_out_r[7:4]}; // RQ2 RQ5 RQ14
  assign cfg[1] = '{fsc_mode_t'(cfg_a_r[FSC_CPU_MODE_LSB +: 2]), tgt_r[1], cs_tol_r[7:4],
                    stop_r[1][7:4], start_r[1][7:4], stime_r[1],
                    cfg_b_r[FSC_CPU_HOLD_BIT], cpu_out_r[7:4]}; // RQ1 RQ5 RQ15 RQ20
  assign cfg[2] = '{fsc_mode_t'(cfg_b_r[FSC_AUX_MODE_LSB +: 2]), tgt_r[2], aux_tol_r[3:0],
                    stop_r[2][7:4], start_r[2][7:4], stime_r[2],
                    cfg_b_r[FSC_AUX_HOLD_BIT], aux_out_r[7:4]}; // RQ3 RQ6 RQ13 RQ16

  // ==========================================================================
  // per-channel drive loop
  logic [3:0] drive_r [3];
  for (genvar c = 0; c < 3; c++) begin : g_chan
    logic [11:0] up_cnt_r, dn_cnt_r, warn_cnt_r;
    logic [7:0]  stop_cnt_r;
    logic        warn_r;
    // temp compares the 7-bit target, speed the whole byte
    wire [8:0] tgt9  = (cfg[c].mode == FSC_MODE_TEMP) ? {2'b00, cfg[c].target[6:0]}
                                                      : {1'b0, cfg[c].target}; // RQ4
    wire [8:0] meas  = (cfg[c].mode == FSC_MODE_TEMP) ? {1'b0, temp_s2_r[c]}
                                                      : {1'b0, tach_s2_r[c]};
    wire [8:0] hi    = tgt9 + {5'h00, cfg[c].tol};
    wire [8:0] lo    = (tgt9 > {5'h00, cfg[c].tol}) ? tgt9 - {5'h00, cfg[c].tol} : 9'h000;
    // a larger tach count means a slower fan, so speed hold needs more drive
    wire       need_up = (cfg[c].mode == FSC_MODE_TEMP) ? meas > hi : meas > hi; // RQ22 RQ23
    wire       need_dn = meas < lo;
    wire       auto_on = cfg[c].mode == FSC_MODE_TEMP || cfg[c].mode == FSC_MODE_SPEED;
    wire [11:0] up_lim = 12'(step_up_r) * 12'(FSC_STEP_TENTHS); // RQ12
    wire [11:0] dn_lim = 12'(step_dn_r) * 12'(FSC_STEP_TENTHS); // RQ11
    wire       up_due = tick && up_cnt_r + 12'h001 >= up_lim;
    wire       dn_due = tick && dn_cnt_r + 12'h001 >= dn_lim;
    wire       is_tmp = cfg[c].mode == FSC_MODE_TEMP;
    wire       floor_ok = drive_r[c] > cfg[c].stop;
    logic [3:0] drive_nxt;

    always_comb begin
      drive_nxt = drive_r[c];
      if (cfg[c].mode == FSC_MODE_MANUAL) drive_nxt = cfg[c].manual; // RQ24
      else if (auto_on && need_up && up_due) begin
        if (is_tmp && drive_r[c] == 4'h0) drive_nxt = cfg[c].start; // RQ9
        else if (drive_r[c] != 4'hf) drive_nxt = drive_r[c] + 4'h1; // RQ22
      end else if (auto_on && need_dn) begin
        if (dn_due && (floor_ok || !is_tmp) && drive_r[c] != 4'h0)
          drive_nxt = drive_r[c] - 4'h1; // RQ7
        else if (is_tmp && !floor_ok && !cfg[c].hold && tick &&
                 stop_cnt_r + 8'h01 >= cfg[c].stime)
          drive_nxt = 4'h0; // RQ10 RQ14 RQ15 RQ16
      end
    end

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        drive_r[c] <= 4'hf;
        up_cnt_r   <= 12'h000;
        dn_cnt_r   <= 12'h000;
        stop_cnt_r <= 8'h00;
        warn_cnt_r <= 12'h000;
        warn_r     <= 1'b0;
      end else begin
        drive_r[c] <= drive_nxt;
        up_cnt_r   <= (!need_up || up_due) ? 12'h000 : up_cnt_r + 12'(tick);
        dn_cnt_r   <= (!need_dn || dn_due) ? 12'h000 : dn_cnt_r + 12'(tick);
        stop_cnt_r <= (!need_dn || floor_ok || drive_r[c] == 4'h0) ? 8'h00
                      : stop_cnt_r + 8'(tick);
        // warning: hot for 3 minutes at full drive
        if (!is_tmp || !(meas > tgt9) || drive_r[c] != 4'hf) begin
          warn_cnt_r <= 12'h000;
          warn_r     <= 1'b0;
        end else if (warn_cnt_r >= 12'(FSC_WARN_TENTHS)) warn_r <= 1'b1; // RQ21
        else warn_cnt_r <= warn_cnt_r + 12'(tick);
      end
    end
    assign warn[c] = warn_r;
  end

  assign system_fan_drive    = drive_r[0];
  assign processor_fan_drive = drive_r[1];
  assign auxiliary_fan_drive = drive_r[2];

  // ==========================================================================
  // over-temperature alert and regulator formula
  logic ovt_latch_r, ovt_prev_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ovt_latch_r      <= 1'b0;
      ovt_prev_r       <= 1'b0;
      overtemp_alert_n <= 1'b1;
    end else begin
      ovt_prev_r <= ovt_sync_r[1];
      // interrupt mode latches the rise until the config is written
      if (w_alert_cfg) ovt_latch_r <= 1'b0;
      if (ovt_sync_r[1] && !ovt_prev_r) ovt_latch_r <= 1'b1;
      if (alert_cfg_r[FSC_ALERT_DIS_BIT]) overtemp_alert_n <= 1'b1; // RQ17
      else if (alert_cfg_r[FSC_ALERT_INT_BIT]) overtemp_alert_n <= !ovt_latch_r; // RQ18
      else overtemp_alert_n <= !ovt_sync_r[1]; // RQ18
    end
  end

  assign regulator_formula_v9 = alert_cfg_r[FSC_REGULATOR_FORMULA_V9_BIT];  // RQ19
  assign regulator_formula_v8 = !alert_cfg_r[FSC_REGULATOR_FORMULA_V9_BIT]; // RQ19

endmodule : fsc_top

// file: rtl/fsc_pkg.sv
// constants, register map and carrier types of the fan speed control block
// How it works
// RQ1: processor fan mode from bits 5-4: manual, temp hold, speed hold, reserved.
// RQ2: system fan mode from bits 3-2, same encoding, manual by default.
// RQ3: auxiliary fan mode from bits 2-1 of second configuration register.
// RQ4: target is 7-bit temperature in temp hold, 8-bit speed otherwise.
// RQ5: shared tolerance: processor in upper nibble, system in lower nibble.
// RQ6: auxiliary tolerance from low nibble of its own register.
// RQ7: temp hold lowers drive down to the channel stop level.
// RQ8: software programs non-zero stop levels before temp hold.
// RQ9: temp hold starts a stopped fan by jumping to start-up level.
// RQ10: stop time sets stop level to zero delay, 0.1 s units.
// RQ11: step-down register sets decrease interval in 1.6 s units.
// RQ12: step-up register sets increase interval in 1.6 s units.
// RQ13: auxiliary manual level is bits 7-4 of its output register, reset all ones.
// RQ14: system hold bit keeps drive at stop level below range, else zero.
// RQ15: processor hold bit keeps drive at stop level below range, else zero.
// RQ16: auxiliary hold bit keeps drive at stop level below range, else zero.
// RQ17: disable bit turns off system over-temperature alert output.
// RQ18: alert mode bit: zero comparator, one interrupt mode.
// RQ19: regulator select bit: one version-9 formula (default), zero version-8.
// RQ20: processor manual level from bits 7-4 of its output value register.
// RQ21: warning bit after 3 minutes above target at full drive in temp hold.
// RQ22: temp hold steps up above target+tol, down below target-tol, per interval.
// RQ23: speed hold steps drive so tach count stays within target plus tolerance.
// RQ24: manual mode drive follows its output value register directly.
package fsc_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] FSC_SYS_OUT_OFS   = 8'h01;
  localparam logic [7:0] FSC_CPU_OUT_OFS   = 8'h03;
  localparam logic [7:0] FSC_CFG_A_OFS     = 8'h04;
  localparam logic [7:0] FSC_SYS_TGT_OFS   = 8'h05;
  localparam logic [7:0] FSC_CPU_TGT_OFS   = 8'h06;
  localparam logic [7:0] FSC_CS_TOL_OFS    = 8'h07;
  localparam logic [7:0] FSC_SYS_STOP_OFS  = 8'h08;
  localparam logic [7:0] FSC_CPU_STOP_OFS  = 8'h09;
  localparam logic [7:0] FSC_SYS_START_OFS = 8'h0a;
  localparam logic [7:0] FSC_CPU_START_OFS = 8'h0b;
  localparam logic [7:0] FSC_SYS_STIME_OFS = 8'h0c;
  localparam logic [7:0] FSC_CPU_STIME_OFS = 8'h0d;
  localparam logic [7:0] FSC_STEP_DN_OFS   = 8'h0e;
  localparam logic [7:0] FSC_STEP_UP_OFS   = 8'h0f;
  localparam logic [7:0] FSC_AUX_OUT_OFS   = 8'h11;
  localparam logic [7:0] FSC_CFG_B_OFS     = 8'h12;
  localparam logic [7:0] FSC_AUX_TGT_OFS   = 8'h13;
  localparam logic [7:0] FSC_AUX_TOL_OFS   = 8'h14;
  localparam logic [7:0] FSC_AUX_STOP_OFS  = 8'h15;
  localparam logic [7:0] FSC_AUX_START_OFS = 8'h16;
  localparam logic [7:0] FSC_AUX_STIME_OFS = 8'h17;
  localparam logic [7:0] FSC_ALERT_CFG_OFS = 8'h18;
  localparam logic [7:0] FSC_WARN_OFS      = 8'h1c;

  // ==========================================================================
  // field positions
  localparam int FSC_CPU_MODE_LSB = 4;
  localparam int FSC_SYS_MODE_LSB = 2;
  localparam int FSC_AUX_MODE_LSB = 1;
  localparam int FSC_SYS_HOLD_BIT = 5;
  localparam int FSC_CPU_HOLD_BIT = 4;
  localparam int FSC_AUX_HOLD_BIT = 3;
  localparam int FSC_ALERT_DIS_BIT = 6;
  localparam int FSC_ALERT_INT_BIT = 4;
  localparam int FSC_REGULATOR_FORMULA_V9_BIT     = 0;

  // ==========================================================================
  // reset values
  localparam logic [7:0] FSC_OUT_RST    = 8'hff;
  localparam logic [7:0] FSC_CFG_A_RST  = 8'h00;
  localparam logic [7:0] FSC_CFG_B_RST  = 8'h00;
  localparam logic [7:0] FSC_ZERO_RST   = 8'h00;
  localparam logic [7:0] FSC_STOP_RST   = 8'h01;
  localparam logic [7:0] FSC_START_RST  = 8'h01;
  localparam logic [7:0] FSC_STIME_RST  = 8'h3c;
  localparam logic [7:0] FSC_STEP_RST   = 8'h01;
  localparam logic [7:0] FSC_ALERT_RST  = 8'h01;

  // ==========================================================================
  // timing
  localparam int FSC_CLK_HZ        = 25_000_000;
  localparam int FSC_TENTH_MS      = 100;
  localparam int FSC_TENTH_CYC     = FSC_CLK_HZ / 1000 * FSC_TENTH_MS;
  localparam int FSC_STEP_TENTHS   = 16;
  localparam int FSC_WARN_S        = 180;
  localparam int FSC_WARN_TENTHS   = FSC_WARN_S * 10;

  typedef enum logic [1:0] {
    FSC_MODE_MANUAL = 2'b00,
    FSC_MODE_TEMP   = 2'b01,
    FSC_MODE_SPEED  = 2'b10,
    FSC_MODE_RSVD   = 2'b11
  } fsc_mode_t;

  // per-channel settings carried into the channel loop
  typedef struct packed {
    fsc_mode_t  mode;
    logic [7:0] target;
    logic [3:0] tol;
    logic [3:0] stop;
    logic [3:0] start;
    logic [7:0] stime;
    logic       hold;
    logic [3:0] manual;
  } fsc_chan_cfg_t;

endpackage : fsc_pkg

// file: dv/fsc_fan_model.sv
// behavioural fans, tachometers and temperature sensors
`timescale 1ns/10ps
module fsc_fan_model (
  input  wire logic [7:0] sys_heat,
  input  wire logic [7:0] cpu_heat,
  input  wire logic [7:0] aux_heat,
  input  wire logic [3:0] system_fan_drive,
  input  wire logic [3:0] processor_fan_drive,
  input  wire logic [3:0] auxiliary_fan_drive,
  output logic      [7:0] system_temp_sense,
  output logic      [7:0] processor_temp_sense,
  output logic      [7:0] auxiliary_temp_sense,
  output logic      [7:0] system_fan_tach,
  output logic      [7:0] processor_fan_tach,
  output logic      [7:0] auxiliary_fan_tach
);
  // ==========================================================================
  // sensors report heat as is; count shrinks as drive grows, stopped fan reads ff
  assign system_temp_sense    = sys_heat;
  assign processor_temp_sense = cpu_heat;
  assign auxiliary_temp_sense = aux_heat;
  assign system_fan_tach      = 8'hff - {system_fan_drive, 4'h0};
  assign processor_fan_tach   = 8'hff - {processor_fan_drive, 4'h0};
  assign auxiliary_fan_tach   = 8'hff - {auxiliary_fan_drive, 4'h0};
endmodule : fsc_fan_model

// file: dv/fsc_top_chk.sv
// concurrent checks on the fan speed control top ports
`timescale 1ns/10ps
module fsc_top_chk
  import fsc_pkg::*;
#(
  parameter int TENTH_CYC = FSC_TENTH_CYC
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       system_overtemp_raw,
  input wire logic [3:0] system_fan_drive,
  input wire logic [3:0] processor_fan_drive,
  input wire logic [3:0] auxiliary_fan_drive,
  input wire logic       overtemp_alert_n,
  input wire logic       regulator_formula_v9,
  input wire logic       regulator_formula_v8
);
  // ==========================================================================
  // shadow copies of the control registers
  logic [7:0] cfg_a_r;
  logic [7:0] cfg_b_r;
  logic [7:0] alert_r;
  logic [3:0] wd_hi;
  logic       wr_alert;
  logic       dis;
  logic       intm;
  assign wd_hi    = reg_wdata[7:4];
  assign wr_alert = reg_wr && reg_addr == FSC_ALERT_CFG_OFS;
  assign dis      = alert_r[FSC_ALERT_DIS_BIT];
  assign intm     = alert_r[FSC_ALERT_INT_BIT];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_a_r <= FSC_CFG_A_RST;
      cfg_b_r <= FSC_CFG_B_RST;
      alert_r <= FSC_ALERT_RST;
    end else if (reg_wr) begin
      if (reg_addr == FSC_CFG_A_OFS) cfg_a_r <= reg_wdata;
      if (reg_addr == FSC_CFG_B_OFS) cfg_b_r <= reg_wdata;
      if (wr_alert) alert_r <= reg_wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // properties; step hold assumes TENTH_CYC above 8
  property p_cfg_rd;
    reg_rd && reg_addr == FSC_CFG_A_OFS |=> reg_rdata == $past(cfg_a_r);
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("config readback");
  property p_cpu_man;
    reg_wr && reg_addr == FSC_CPU_OUT_OFS && cfg_a_r[5:4] == FSC_MODE_MANUAL
      |=> ##1 processor_fan_drive == $past(wd_hi, 2);
  endproperty
  a_cpu_man: assert property (p_cpu_man) else $error("cpu manual level");
  property p_aux_man;
    reg_wr && reg_addr == FSC_AUX_OUT_OFS && cfg_b_r[2:1] == FSC_MODE_MANUAL
      |=> ##1 auxiliary_fan_drive == $past(wd_hi, 2);
  endproperty
  a_aux_man: assert property (p_aux_man) else $error("aux manual level");
  property p_rst_drv;
    $rose(rst_n) |-> {system_fan_drive, processor_fan_drive, auxiliary_fan_drive} == 12'hfff;
  endproperty
  a_rst_drv: assert property (p_rst_drv) else $error("drive after reset");
  property p_vrm;
    $stable(alert_r) |-> regulator_formula_v9 == alert_r[0] && regulator_formula_v8 == !alert_r[0];
  endproperty
  a_vrm: assert property (p_vrm) else $error("formula select");
  property p_ovt_off;
    dis && $past(dis) |-> overtemp_alert_n;
  endproperty
  a_ovt_off: assert property (p_ovt_off) else $error("alert not off");
  property p_ovt_cmp;
    (!dis && !intm && system_overtemp_raw)[*5] |-> !overtemp_alert_n;
  endproperty
  a_ovt_cmp: assert property (p_ovt_cmp) else $error("comparator alert");
  property p_ovt_latch;
    intm && !dis && !overtemp_alert_n && !wr_alert && !$past(wr_alert) |=> !overtemp_alert_n;
  endproperty
  a_ovt_latch: assert property (p_ovt_latch) else $error("alert latch lost");
  property p_step;
    cfg_a_r[5:4] == FSC_MODE_TEMP && $past(cfg_a_r[5:4]) == FSC_MODE_TEMP
      && $changed(processor_fan_drive) |=> $stable(processor_fan_drive)[*8];
  endproperty
  a_step: assert property (p_step) else $error("step faster than tick");
endmodule : fsc_top_chk

bind fsc_top fsc_top_chk #(.TENTH_CYC(TENTH_CYC)) i_chk (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .system_overtemp_raw(system_overtemp_raw),
  .system_fan_drive(system_fan_drive), .processor_fan_drive(processor_fan_drive),
  .auxiliary_fan_drive(auxiliary_fan_drive), .overtemp_alert_n(overtemp_alert_n),
  .regulator_formula_v9(regulator_formula_v9), .regulator_formula_v8(regulator_formula_v8));

// file: dv/fan_speed_control_test.sv
// self-checking bench for the fan speed control block
`timescale 1ns/10ps
module fan_speed_control_test
  import fsc_pkg::*;
;
  logic       clk;
  logic       rst_n;
  logic [7:0] addr, wdata, rdata;
  logic       wr_s, rd_s, ovt_raw, ovt_n, v9, v8;
  logic [7:0] h_sys, h_cpu, h_aux, ts_s, ts_c, ts_a, tc_s, tc_c, tc_a;
  logic [3:0] d_sys, d_cpu, d_aux;
  int         failures, checks_done, cyc, n;
  logic [7:0] r_ofs [7] = '{8'h04, 8'h0a, 8'h11, 8'h15, 8'h18, 8'h0c, 8'h10};
  logic [7:0] r_val [7] = '{8'h00, 8'h01, 8'hff, 8'h01, 8'h01, 8'h3c, 8'h00};
  // non-zero stop levels before temperature holding
  logic [7:0] c_ofs [16] = '{8'h06, 8'h13, 8'h07, 8'h14, 8'h09, 8'h15, 8'h0b, 8'h16,
    8'h0d, 8'h17, 8'h0f, 8'h0e, 8'h03, 8'h11, 8'h12, 8'h04};
  logic [7:0] c_val [16] = '{8'hb0, 8'hb0, 8'h28, 8'h32, 8'h40, 8'h40, 8'h80, 8'h80,
    8'h05, 8'h05, 8'h01, 8'h01, 8'h00, 8'h00, 8'h12, 8'h10};

  fsc_top #(.TENTH_CYC(10)) i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata),
    .system_temp_sense(ts_s), .processor_temp_sense(ts_c), .auxiliary_temp_sense(ts_a),
    .system_fan_tach(tc_s), .processor_fan_tach(tc_c), .auxiliary_fan_tach(tc_a),
    .system_overtemp_raw(ovt_raw), .system_fan_drive(d_sys), .processor_fan_drive(d_cpu),
    .auxiliary_fan_drive(d_aux), .overtemp_alert_n(ovt_n), .regulator_formula_v9(v9),
    .regulator_formula_v8(v8));
  fsc_fan_model i_fan (.sys_heat(h_sys), .cpu_heat(h_cpu), .aux_heat(h_aux),
    .system_fan_drive(d_sys), .processor_fan_drive(d_cpu), .auxiliary_fan_drive(d_aux),
    .system_temp_sense(ts_s), .processor_temp_sense(ts_c), .auxiliary_temp_sense(ts_a),
    .system_fan_tach(tc_s), .processor_fan_tach(tc_c), .auxiliary_fan_tach(tc_a));

  // ==========================================================================
  // shared tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
    #1;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rd_chk
  task automatic heat(input logic [7:0] v);
    @(posedge clk);
    h_cpu <= v;
    h_aux <= v;
  endtask : heat
  task automatic ovt(input logic v);
    @(posedge clk);
    ovt_raw <= v;
  endtask : ovt
  function automatic logic [3:0] drv(input int c);
    return (c == 0) ? d_sys : (c == 1) ? d_cpu : d_aux;
  endfunction : drv
  // bounded wait; n is cycles spent
  task automatic wait_d(input int c, input logic [3:0] v, input int lim);
    n = 0;
    while (drv(c) !== v && n < lim) begin
      tick(1);
      n++;
    end
    chk(drv(c), v);
  endtask : wait_d

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    for (int i = 0; i < 7; i++) rd_chk(r_ofs[i], r_val[i]);
    chk({d_aux, 2'b00, v9, v8}, 8'hf2);
  endtask : t_reset
  task automatic t_manual();
    wr(FSC_SYS_OUT_OFS, 8'h3a);
    wr(FSC_CPU_OUT_OFS, 8'h5c);
    wr(FSC_AUX_OUT_OFS, 8'h96);
    wr(FSC_CFG_A_OFS, 8'h30);
    wr(FSC_CFG_B_OFS, 8'h06);
    chk({d_sys, d_cpu}, 8'h35);
    wr(FSC_CPU_OUT_OFS, 8'he0);
    wr(FSC_AUX_OUT_OFS, 8'he0);
    tick(2);
    chk({d_cpu, d_aux}, 8'h59);
    wr(FSC_CFG_A_OFS, 8'h00);
    wr(FSC_CFG_B_OFS, 8'h00);
    tick(2);
    chk({d_cpu, d_aux}, 8'hee);
  endtask : t_manual
  task automatic t_speed();
    wr(FSC_SYS_TGT_OFS, 8'h88);
    wr(FSC_CS_TOL_OFS, 8'h28);
    wr(FSC_STEP_DN_OFS, 8'h00);
    wr(FSC_STEP_UP_OFS, 8'h00);
    wr(FSC_SYS_OUT_OFS, 8'hf0);
    wr(FSC_CFG_A_OFS, 8'h08);
    wait_d(0, 4'h7, 400);
    tick(300);
    chk(d_sys, 8'h07);
  endtask : t_speed
  task automatic t_temp();
    heat(8'h40);
    for (int i = 0; i < 16; i++) wr(c_ofs[i], c_val[i]);
    wait_d(1, 4'h8, 250);
    chk(d_aux, 8'h08);
    wait_d(1, 4'h9, 250);
    chk(8'(n > 150 && n < 175), 8'h01);
    wait_d(1, 4'hf, 1300);
    chk(d_aux, 8'h0f);
    tick(18010);
    rd_chk(FSC_WARN_OFS, 8'h06);
    heat(8'h20);
    wait_d(1, 4'h5, 1900);
    wait_d(1, 4'h4, 250);
    chk(8'(n > 150 && n < 175), 8'h01);
    wait_d(2, 4'h0, 100);
    chk(8'(n > 30 && n < 65), 8'h01);
    tick(400);
    chk(d_cpu, 8'h04);
    heat(8'h40);
    wait_d(2, 4'h8, 250);
  endtask : t_temp
  task automatic t_alert();
    ovt(1'b1);
    tick(6);
    chk(ovt_n, 1'b0);
    ovt(1'b0);
    tick(6);
    chk(ovt_n, 1'b1);
    wr(FSC_ALERT_CFG_OFS, 8'h11);
    ovt(1'b1);
    ovt(1'b0);
    tick(8);
    chk(ovt_n, 1'b0);
    wr(FSC_ALERT_CFG_OFS, 8'h11);
    tick(4);
    chk(ovt_n, 1'b1);
    wr(FSC_ALERT_CFG_OFS, 8'h50);
    ovt(1'b1);
    tick(6);
    chk({ovt_n, v9, v8}, 8'h05);
    ovt(1'b0);
  endtask : t_alert

  task automatic summarize();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // hang guard above the ~22k cycles the scenarios need, warning wait included
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc == 30000) begin
        failures++;
        summarize();
      end
    end
  end
  initial begin
    {rst_n, wr_s, rd_s, ovt_raw} = 4'h0;
    {addr, wdata, h_sys, h_cpu, h_aux} = 40'h0;
    failures = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_manual();
    t_speed();
    t_temp();
    t_alert();
    summarize();
  end
endmodule : fan_speed_control_test
